// >>> serial_eeprom_cache_security.sv
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_regs.svh"
module serial_eeprom_cache_security #(
    parameter int unsigned PAGE_CYCLES = `PAGE_TIME_NS / `CLOCK_PERIOD_NS
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [2:0] i_chip_select_address_bits,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_busy,
    output logic o_standby,
    output logic o_prot_set,
    output logic [3:0] o_prot_start,
    output logic [3:0] o_prot_count,
    output logic [3:0] o_he_block,
    output eeprom_pkg::cmd_e o_last_cmd
);
    import eeprom_pkg::*;

    localparam int WAIT_W = $clog2(PAGE_CYCLES + 1);

    // ****************************************
    // Helper functions.
    // ****************************************
    function automatic logic [`ARRAY_AW-1:0] cache_to_array(input logic [`ARRAY_AW-1:0] base,
                                                           input logic [`CACHE_AW-1:0] idx);
        logic [`ARRAY_AW-4:0] page;
        page = base[`ARRAY_AW-1:3] + {7'h00, idx[5:3]};
        return {page, idx[2:0]};
    endfunction

    function automatic logic is_protected(input logic [`ARRAY_AW-1:0] addr, input logic [3:0] start,
                                          input logic [3:0] count);
        logic [4:0] blk;
        logic [4:0] limit;
        blk = {1'b0, addr[`BLOCK_MSB:`BLOCK_LSB]};
        limit = {1'b0, start} + {1'b0, count};
        return (count != 4'h0) && (blk >= {1'b0, start}) && (blk < limit);
    endfunction

    function automatic logic page_used(input logic [63:0] valid, input logic [2:0] page);
        return valid[{page, 3'h0} +: 8] != 8'h00;
    endfunction

    // ****************************************
    // Storage.
    // ****************************************
    mem_port_if #(.AW(`CACHE_AW), .DW(8)) cache_port ();
    mem_port_if #(.AW(`ARRAY_AW), .DW(8)) array_port ();

    dual_clock_ram #(.AW(`CACHE_AW), .DW(8)) cache_ram (
        .i_wclk(i_scl),
        .i_rclk(i_clock),
        .port(cache_port)
    );

    dual_clock_ram #(.AW(`ARRAY_AW), .DW(8)) array_ram (
        .i_wclk(i_clock),
        .i_rclk(i_scl),
        .port(array_port)
    );

    // ****************************************
    // Start and stop detection on data edges.
    // ****************************************
    logic start_tog_ff;
    logic stop_tog_ff;

    always_ff @(negedge i_sda or posedge i_reset) begin
        if (i_reset) begin
            start_tog_ff <= 1'b0;
        end else if (i_scl) begin
            start_tog_ff <= ~start_tog_ff;
        end
    end

    always_ff @(posedge i_sda or posedge i_reset) begin
        if (i_reset) begin
            stop_tog_ff <= 1'b0;
        end else if (i_scl) begin
            stop_tog_ff <= ~stop_tog_ff;
        end
    end

    // ****************************************
    // Link side, clocked by the serial clock.
    // ****************************************
    logic busy_ff;
    logic [3:0] prot_start_ff;
    logic [3:0] prot_count_ff;
    logic [11:0] link_sync;
    logic busy_link;
    logic [2:0] cs_link;
    logic [3:0] prot_start_link;
    logic [3:0] prot_count_link;

    // Configuration only changes on a stop while the write engine is idle, so the word is quasi-static.
    level_sync #(.WIDTH(12)) link_sync_u (
        .i_clock(i_scl),
        .i_reset(i_reset),
        .i_level({busy_ff, i_chip_select_address_bits, prot_start_ff, prot_count_ff}),
        .o_level(link_sync)
    );
    assign busy_link = link_sync[11];
    assign cs_link = link_sync[10:8];
    assign prot_start_link = link_sync[7:4];
    assign prot_count_link = link_sync[3:0];

    link_state_e state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] rx_sr_ff;
    logic [7:0] tx_sr_ff;
    logic start_seen_ff;
    logic ack_ff;
    logic tx_first_ff;
    logic oe_ff;
    logic [4:0] addr_hi_ff;
    logic [`ARRAY_AW-1:0] ptr_ff;
    logic [`ARRAY_AW-1:0] base_ff;
    logic [`CACHE_AW-1:0] load_idx_ff;
    logic [63:0] valid_ff;
    cmd_e cmd_ff;
    logic [3:0] cfg_start_ff;
    logic [3:0] cfg_count_ff;

    logic start_pending;
    logic byte_done;
    logic is_tx;
    logic tx_load;
    logic [7:0] rx_byte;

    assign start_pending = start_tog_ff ^ start_seen_ff;
    assign is_tx = (state_ff == L_TX) || (state_ff == L_CFG_TX);
    assign byte_done = !start_pending && !is_tx && (bit_cnt_ff == `LAST_BIT);
    assign tx_load = !start_pending && is_tx && (bit_cnt_ff == `ACK_SLOT) && (tx_first_ff || !i_sda);
    assign rx_byte = {rx_sr_ff[6:0], i_sda};

    // Bit counter and receive shifter.
    always_ff @(posedge i_scl or posedge i_reset) begin
        if (i_reset) begin
            bit_cnt_ff <= 4'h0;
            rx_sr_ff <= 8'h00;
            start_seen_ff <= 1'b0;
        end else begin
            start_seen_ff <= start_tog_ff;
            rx_sr_ff <= {rx_sr_ff[6:0], i_sda};
            if (start_pending) begin
                bit_cnt_ff <= 4'h1;
            end else if (bit_cnt_ff == `ACK_SLOT) begin
                bit_cnt_ff <= 4'h0;
            end else begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
        end
    end

    // Protocol state and acknowledge decision.
    always_ff @(posedge i_scl or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= L_IDLE;
            ack_ff <= 1'b0;
            tx_first_ff <= 1'b0;
        end else if (start_pending) begin
            state_ff <= L_CTRL;
            ack_ff <= 1'b0;
            tx_first_ff <= 1'b0;
        end else if (byte_done) begin
            ack_ff <= 1'b1;
            case (state_ff)
                L_CTRL: begin
                    if (rx_byte[7:4] == `CTRL_TYPE_CODE && rx_byte[3:1] == cs_link && !busy_link) begin
                        state_ff <= rx_byte[0] ? L_TX : L_ADDR_HI;
                        tx_first_ff <= rx_byte[0];
                    end else begin
                        ack_ff <= 1'b0;
                        state_ff <= L_IDLE;
                    end
                end
                L_ADDR_HI: begin
                    state_ff <= rx_byte[`CFG_FLAG_BIT] ? L_CFG_DUMMY : L_ADDR_LO;
                end
                L_ADDR_LO: begin
                    state_ff <= L_DATA;
                end
                L_DATA: begin
                    state_ff <= L_DATA;
                end
                L_CFG_DUMMY: begin
                    state_ff <= L_CFG_BYTE;
                end
                L_CFG_BYTE: begin
                    if (rx_byte[`CFG_READ_BIT]) begin
                        state_ff <= L_CFG_TX;
                        tx_first_ff <= 1'b1;
                    end else begin
                        state_ff <= L_IDLE;
                    end
                end
                default: begin
                    ack_ff <= 1'b0;
                    state_ff <= L_IDLE;
                end
            endcase
        end else if (bit_cnt_ff == `ACK_SLOT) begin
            ack_ff <= 1'b0;
            if (is_tx) begin
                tx_first_ff <= 1'b0;
                if (!tx_first_ff && i_sda) begin
                    state_ff <= L_IDLE;
                end
            end
        end
    end

    // Address pointer, cache loading and captured command.
    always_ff @(posedge i_scl or posedge i_reset) begin
        if (i_reset) begin
            addr_hi_ff <= 5'h00;
            ptr_ff <= '0;
            base_ff <= '0;
            load_idx_ff <= '0;
            valid_ff <= 64'h0000000000000000;
            cmd_ff <= CMD_NONE;
            cfg_start_ff <= 4'h0;
            cfg_count_ff <= 4'h0;
        end else if (start_pending) begin
            cmd_ff <= CMD_NONE;
        end else if (tx_load && state_ff == L_TX) begin
            ptr_ff <= ptr_ff + 13'h0001;
        end else if (byte_done) begin
            case (state_ff)
                L_ADDR_HI: begin
                    addr_hi_ff <= rx_byte[4:0];
                    cfg_start_ff <= rx_byte[4:1];
                end
                L_ADDR_LO: begin
                    ptr_ff <= {addr_hi_ff, rx_byte};
                    base_ff <= {addr_hi_ff, rx_byte};
                    load_idx_ff <= {3'h0, rx_byte[2:0]};
                    valid_ff <= 64'h0000000000000000;
                end
                L_DATA: begin
                    valid_ff[load_idx_ff] <= 1'b1;
                    load_idx_ff <= load_idx_ff + 6'h01;
                    ptr_ff <= {ptr_ff[12:6], ptr_ff[5:0] + 6'h01};
                    cmd_ff <= CMD_DATA;
                end
                L_CFG_BYTE: begin
                    if (!rx_byte[`CFG_READ_BIT]) begin
                        cmd_ff <= rx_byte[`ENDURANCE_SEL_BIT] ? CMD_PROT : CMD_HE;
                        cfg_count_ff <= rx_byte[3:0];
                    end
                end
                default: begin
                    cmd_ff <= cmd_ff;
                end
            endcase
        end
    end

    assign cache_port.wr_en = byte_done && (state_ff == L_DATA);
    assign cache_port.wr_addr = load_idx_ff;
    assign cache_port.wr_data = rx_byte;
    assign array_port.rd_addr = ptr_ff;

    // Transmit shifter for array data and configuration readback.
    always_ff @(posedge i_scl or posedge i_reset) begin
        if (i_reset) begin
            tx_sr_ff <= 8'hFF;
        end else if (tx_load) begin
            if (state_ff == L_TX) begin
                tx_sr_ff <= array_port.rd_data;
            end else if (tx_first_ff) begin
                tx_sr_ff <= {`CFG_READ_PAD, prot_start_link};
            end else begin
                tx_sr_ff <= {`CFG_READ_PAD, prot_count_link};
            end
        end else if (is_tx && bit_cnt_ff < `ACK_SLOT) begin
            tx_sr_ff <= {tx_sr_ff[6:0], 1'b1};
        end
    end

    // Data line is changed only while the serial clock is low.
    always_ff @(negedge i_scl or posedge i_reset) begin
        if (i_reset) begin
            oe_ff <= 1'b0;
        end else if (bit_cnt_ff == `ACK_SLOT) begin
            oe_ff <= ack_ff;
        end else if (is_tx) begin
            oe_ff <= ~tx_sr_ff[7];
        end else begin
            oe_ff <= 1'b0;
        end
    end

    assign o_sda_out = 1'b0;
    assign o_sda_oe = oe_ff;

    // ****************************************
    // Core side, clocked by the system clock.
    // ****************************************
    logic [1:0] frame_sync;
    logic [1:0] frame_prev_ff;
    logic start_evt;
    logic stop_evt;
    logic frame_ff;

    level_sync #(.WIDTH(2)) frame_sync_u (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_level({stop_tog_ff, start_tog_ff}),
        .o_level(frame_sync)
    );
    assign start_evt = frame_sync[0] ^ frame_prev_ff[0];
    assign stop_evt = frame_sync[1] ^ frame_prev_ff[1];

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            frame_prev_ff <= 2'h0;
            frame_ff <= 1'b0;
        end else begin
            frame_prev_ff <= frame_sync;
            if (stop_evt) begin
                frame_ff <= 1'b0;
            end else if (start_evt) begin
                frame_ff <= 1'b1;
            end
        end
    end

    eng_state_e eng_state_ff;
    logic [5:0] eng_idx_ff;
    logic [WAIT_W-1:0] wait_cnt_ff;
    logic [`ARRAY_AW-1:0] eng_base_ff;
    logic [63:0] eng_valid_ff;
    logic prot_set_ff;
    logic [3:0] he_block_ff;
    cmd_e last_cmd_ff;
    logic launch;
    logic [`ARRAY_AW-1:0] eng_addr;

    assign launch = stop_evt && (eng_state_ff == E_IDLE);
    assign eng_addr = cache_to_array(eng_base_ff, eng_idx_ff);

    // Kept settings: reset stands for the power-on factory state.
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            prot_start_ff <= `PROT_START_DEF;
            prot_count_ff <= `PROT_COUNT_DEF;
            prot_set_ff <= 1'b0;
            he_block_ff <= `HE_BLOCK_DEF;
            last_cmd_ff <= CMD_NONE;
        end else if (launch) begin
            last_cmd_ff <= cmd_ff;
            if (cmd_ff == CMD_PROT && !prot_set_ff) begin
                prot_start_ff <= cfg_start_ff;
                prot_count_ff <= cfg_count_ff;
                prot_set_ff <= 1'b1;
            end else if (cmd_ff == CMD_HE && !prot_set_ff) begin
                he_block_ff <= cfg_start_ff;
            end
        end
    end

    // Write engine: one pass over the cache, one page time per loaded page.
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            eng_state_ff <= E_IDLE;
            eng_idx_ff <= 6'h00;
            wait_cnt_ff <= '0;
            eng_base_ff <= '0;
            eng_valid_ff <= 64'h0000000000000000;
        end else begin
            case (eng_state_ff)
                E_IDLE: begin
                    if (launch && cmd_ff == CMD_DATA) begin
                        eng_state_ff <= E_READ;
                        eng_idx_ff <= 6'h00;
                        eng_base_ff <= base_ff;
                        eng_valid_ff <= valid_ff;
                    end
                end
                E_READ: begin
                    eng_state_ff <= E_WRITE;
                end
                E_WRITE: begin
                    wait_cnt_ff <= '0;
                    if (eng_idx_ff[2:0] == 3'h7 && page_used(eng_valid_ff, eng_idx_ff[5:3])) begin
                        eng_state_ff <= E_WAIT;
                    end else if (eng_idx_ff == 6'h3F) begin
                        eng_state_ff <= E_IDLE;
                    end else begin
                        eng_idx_ff <= eng_idx_ff + 6'h01;
                        eng_state_ff <= E_READ;
                    end
                end
                E_WAIT: begin
                    wait_cnt_ff <= wait_cnt_ff + 1'b1;
                    if (wait_cnt_ff == WAIT_W'(PAGE_CYCLES - 1)) begin
                        if (eng_idx_ff == 6'h3F) begin
                            eng_state_ff <= E_IDLE;
                        end else begin
                            eng_idx_ff <= eng_idx_ff + 6'h01;
                            eng_state_ff <= E_READ;
                        end
                    end
                end
                default: begin
                    eng_state_ff <= E_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (eng_state_ff != E_IDLE) || (launch && cmd_ff == CMD_DATA);
        end
    end

    assign cache_port.rd_addr = eng_idx_ff;
    assign array_port.wr_en = (eng_state_ff == E_WRITE) && eng_valid_ff[eng_idx_ff]
                              && !is_protected(eng_addr, prot_start_ff, prot_count_ff);
    assign array_port.wr_addr = eng_addr;
    assign array_port.wr_data = cache_port.rd_data;

    assign o_busy = busy_ff;
    assign o_standby = !frame_ff && !busy_ff && (eng_state_ff == E_IDLE);
    assign o_prot_set = prot_set_ff;
    assign o_prot_start = prot_start_ff;
    assign o_prot_count = prot_count_ff;
    assign o_he_block = he_block_ff;
    assign o_last_cmd = last_cmd_ff;
endmodule
`default_nettype wire

// >>> eeprom_regs.svh
// Behaviour
// - First byte after start: type code, three chip-select bits, read/write bit set for read.
// - Configuration byte with leading bit clear relocates the high-endurance block.
// - No relocation once protection is set; high-endurance block defaults to highest block.
// - Protection covers zero to fifteen contiguous blocks from a start block.
// - Count zero leaves array writable; defaults are start fifteen, count zero.
// - Protection setting is accepted once; later attempts change nothing.
// - Protection address byte has top bit set, start block in bits one to four.
// - Second protection byte is ignored and acknowledged.
// - Third byte: select bit high, read bit low, count in bits zero to three.
// - Bytes aimed at protected addresses are silently dropped without abort.
// - Writes across the protected boundary store only unprotected bytes.
// - With the read bit set the device acknowledges then sends two bytes.
// - Config bytes read ones in upper nibble; start block then block count.
// - During the write cycle no command is acknowledged; masters poll.
// - Up to 64 bytes are cached until stop launches the write cycle.
// - Each loaded page takes one page time, partial pages included.
// - Loading past 64 bytes wraps to cache page 0 and overwrites.
// - Cached pages go to consecutive array pages, across block boundaries.
// - First byte lands in cache page 0 at low address bits; page 0 maps to start page.
// - Only loaded bytes are programmed; other bytes stay untouched.
// - Standby once stop is seen and internal activity is over.
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH
`define CTRL_TYPE_CODE 4'hA
`define CFG_FLAG_BIT 7
`define ENDURANCE_SEL_BIT 7
`define CFG_READ_BIT 6
`define CFG_READ_PAD 4'hF
`define PROT_START_DEF 4'hF
`define PROT_COUNT_DEF 4'h0
`define HE_BLOCK_DEF 4'hF
`define PAGE_TIME_NS 5000000
`define CLOCK_PERIOD_NS 50
`define ARRAY_AW 13
`define CACHE_AW 6
`define BLOCK_MSB 12
`define BLOCK_LSB 9
`define LAST_BIT 4'h7
`define ACK_SLOT 4'h8
`endif

// >>> eeprom_pkg.sv
package eeprom_pkg;
    typedef enum logic [3:0] {
        L_IDLE, L_CTRL, L_ADDR_HI, L_ADDR_LO, L_DATA, L_CFG_DUMMY, L_CFG_BYTE, L_TX, L_CFG_TX
    } link_state_e;
    typedef enum logic [1:0] {CMD_NONE, CMD_DATA, CMD_PROT, CMD_HE} cmd_e;
    typedef enum logic [1:0] {E_IDLE, E_READ, E_WRITE, E_WAIT} eng_state_e;
endpackage

// >>> mem_port_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mem_port_if #(parameter int AW = 6, parameter int DW = 8);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> level_sync.sv
`timescale 1ns/100ps
`default_nettype none
module level_sync #(parameter int WIDTH = 1) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_level,
    output logic [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;

    // A bit changes only once the second and third stages agree.
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
            o_level <= '0;
        end else begin
            stage1_ff <= i_level;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            o_level <= (stage2_ff & stage3_ff) | (o_level & (stage2_ff | stage3_ff));
        end
    end
endmodule
`default_nettype wire

// >>> dual_clock_ram.sv
`timescale 1ns/100ps
`default_nettype none
module dual_clock_ram #(parameter int AW = 6, parameter int DW = 8) (
    input wire logic i_wclk,
    input wire logic i_rclk,
    mem_port_if.mem port
);
    logic [DW-1:0] mem_ff [0:(1 << AW)-1];

    always_ff @(posedge i_wclk) begin
        if (port.wr_en) begin
            mem_ff[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge i_rclk) begin
        port.rd_data <= mem_ff[port.rd_addr];
    end
endmodule
`default_nettype wire

// >>> eeprom_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker.
// ****
module eeprom_checker #(parameter int unsigned PAGE_CYCLES = 20) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_busy,
    input wire logic o_standby,
    input wire logic o_prot_set,
    input wire logic [3:0] o_prot_start,
    input wire logic [3:0] o_prot_count,
    input wire logic [3:0] o_he_block,
    input wire eeprom_pkg::cmd_e o_last_cmd
);
    import eeprom_pkg::*;
    logic [15:0] busy_len_ff;
    always_ff @(posedge i_clock) begin
        busy_len_ff <= (i_reset || !o_busy) ? 16'h0 : busy_len_ff + 16'h1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    a_drive_low: assert property (o_sda_out == 1'h0)
        else $error("data drive value not low");
    a_prot_default: assert property (!o_prot_set |-> o_prot_start == 4'hF && o_prot_count == 4'h0)
        else $error("protection not at default");
    a_prot_sticky: assert property (o_prot_set |=> o_prot_set && $stable(o_prot_start) && $stable(o_prot_count))
        else $error("protection changed after set");
    a_he_locked: assert property (o_prot_set |=> $stable(o_he_block))
        else $error("endurance block moved after protection");
    a_busy_standby: assert property (o_busy |-> !o_standby)
        else $error("standby while busy");
    a_busy_no_ack: assert property (o_busy && $past(o_busy, 8) |-> !o_sda_oe)
        else $error("line driven during write cycle");
    a_busy_data: assert property ($rose(o_busy) |-> ##[0:2] o_last_cmd == CMD_DATA)
        else $error("write cycle without data write");
    a_page_time: assert property ($fell(o_busy) |-> busy_len_ff >= 16'(PAGE_CYCLES))
        else $error("write cycle shorter than a page time");
    a_standby_after: assert property ($fell(o_busy) |-> ##[0:60] o_standby)
        else $error("no standby after write cycle");
endmodule
`default_nettype wire

// >>> bus_master.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Two-wire bus master model.
// ****
module bus_master (
    output logic o_scl,
    output logic o_sda,
    input wire logic i_line
);
    initial begin
        o_scl = 1'h1;
        o_sda = 1'h1;
    end
    task automatic clk_bit(input logic b, output logic s);
        o_sda = b;
        #16 o_scl = 1'h1;
        #16 s = i_line;
        #16 o_scl = 1'h0;
        #16;
    endtask
    task automatic idle(input int n);
        logic s;
        repeat (n) clk_bit(1'h1, s);
        o_scl = 1'h1;
    endtask
    task automatic start();
        o_sda = 1'h1;
        #16 o_scl = 1'h1;
        #16 o_sda = 1'h0;
        #16 o_scl = 1'h0;
        #16;
    endtask
    task automatic stop();
        o_sda = 1'h0;
        #16 o_scl = 1'h1;
        #16 o_sda = 1'h1;
        #32;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'h1, s);
        ack = ~s;
    endtask
    task automatic get_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'h1, s);
            b[i] = s;
        end
        clk_bit(~ack, s);
    endtask
endmodule
`default_nettype wire

// >>> serial_eeprom_cache_security_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Testbench.
// ****
module serial_eeprom_cache_security_tb_top;
    import eeprom_pkg::*;
    localparam int unsigned PAGE_CYCLES = 20;
    localparam logic [7:0] CTRL_W = 8'hAA;
    logic i_clock = 1'h0;
    logic i_reset = 1'h0;
    logic [2:0] chip_bits = 3'h5;
    logic scl, sda_m, sda_oe, busy, standby, prot_set, ack;
    logic [3:0] prot_start, prot_count, he_block;
    logic [7:0] rd;
    cmd_e last_cmd;
    int num_errors = 0;
    int compares = 0;
    int len_a;
    int len_b;
    wire logic sda_line = sda_m & ~sda_oe;
    always #25 i_clock = ~i_clock;
    serial_eeprom_cache_security #(.PAGE_CYCLES(PAGE_CYCLES)) u_serial_eeprom_cache_security (
        .i_clock(i_clock), .i_reset(i_reset), .i_scl(scl), .i_sda(sda_line),
        .i_chip_select_address_bits(chip_bits), .o_sda_out(), .o_sda_oe(sda_oe), .o_busy(busy),
        .o_standby(standby), .o_prot_set(prot_set), .o_prot_start(prot_start),
        .o_prot_count(prot_count), .o_he_block(he_block), .o_last_cmd(last_cmd));
    bus_master u_bus_master (.o_scl(scl), .o_sda(sda_m), .i_line(sda_line));
    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic exp);
        u_bus_master.put_byte(b, ack);
        chk({7'h0, ack}, {7'h0, exp});
    endtask
    task automatic t_cfg(input logic [7:0] first, input logic [7:0] cfg);
        u_bus_master.start();
        send(CTRL_W, 1'h1);
        send(first, 1'h1);
        send(8'h5A, 1'h1);
        send(cfg, 1'h1);
        if (cfg[6]) begin
            u_bus_master.get_byte(1'h1, rd);
            chk(rd, 8'hF5);
            u_bus_master.get_byte(1'h0, rd);
            chk(rd, 8'hF3);
        end
        u_bus_master.stop();
        repeat (10) @(negedge i_clock);
        chk({7'h0, busy}, 8'h0);
    endtask
    task automatic t_write(input logic [7:0] hi, input logic [7:0] lo, input int n, output int len);
        int k;
        u_bus_master.start();
        send(CTRL_W, 1'h1);
        send(hi, 1'h1);
        send(lo, 1'h1);
        for (k = 0; k < n; k++) send(8'h30 + k[7:0], 1'h1);
        u_bus_master.stop();
        len = 0;
        k = 0;
        while (busy !== 1'h1 && k < 40) begin
            @(negedge i_clock);
            k++;
        end
        chk({7'h0, busy}, 8'h1);
        u_bus_master.start();
        send(CTRL_W, 1'h0);
        u_bus_master.stop();
        while (busy === 1'h1 && len < 5000) begin
            @(negedge i_clock);
            len++;
        end
        chk({6'h0, last_cmd}, {6'h0, CMD_DATA});
        repeat (4) @(negedge i_clock);
        chk({7'h0, standby}, 8'h1);
        u_bus_master.start();
        send(CTRL_W, 1'h1);
        u_bus_master.stop();
    endtask
    task automatic t_read(input logic [15:0] a, input logic [7:0] exp);
        u_bus_master.start();
        send(CTRL_W, 1'h1);
        send(a[15:8], 1'h1);
        send(a[7:0], 1'h1);
        u_bus_master.start();
        send(8'hAB, 1'h1);
        u_bus_master.get_byte(1'h0, rd);
        u_bus_master.stop();
        chk(rd, exp);
    endtask
    task automatic t_reset();
        chk({4'h0, he_block}, 8'h0F);
        chk({prot_start, prot_count}, 8'hF0);
        chk({6'h0, standby, prot_set}, 8'h2);
    endtask
    task automatic t_select();
        u_bus_master.start();
        send(8'hA8, 1'h0);
        u_bus_master.stop();
        u_bus_master.start();
        send(8'h6A, 1'h0);
        u_bus_master.stop();
    endtask
    task automatic t_protect();
        t_cfg(8'h8C, 8'h00);
        chk({4'h0, he_block}, 8'h06);
        t_cfg(8'hEB, 8'hB3);
        chk({3'h0, prot_set, prot_start}, 8'h15);
        chk({4'h0, prot_count}, 8'h03);
        t_cfg(8'h84, 8'h00);
        chk({4'h0, he_block}, 8'h06);
        t_cfg(8'h82, 8'h87);
        chk({prot_start, prot_count}, 8'h53);
        t_cfg(8'hEB, 8'hC0);
    endtask
    initial begin
        i_reset <= 1'h1;
        repeat (3) @(posedge i_clock);
        i_reset <= 1'h0;
        u_bus_master.idle(4);
        t_reset();
        t_select();
        t_write(8'h0F, 8'hF8, 1, len_a);
        t_write(8'h0F, 8'hF8, 9, len_b);
        chk({7'h0, len_b - len_a >= PAGE_CYCLES && len_b - len_a < 2 * PAGE_CYCLES}, 8'h1);
        t_protect();
        t_write(8'h0F, 8'hF9, 9, len_a);
        t_read(16'h0FF9, 8'h31);
        t_read(16'h1000, 8'h37);
        t_read(16'h0FF8, 8'h30);
        test_done();
    end
    initial begin
        #2000000;
        num_errors++;
        test_done();
    end
endmodule
bind serial_eeprom_cache_security eeprom_checker #(.PAGE_CYCLES(PAGE_CYCLES)) u_eeprom_checker (
    .i_clock(i_clock), .i_reset(i_reset), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .o_busy(o_busy), .o_standby(o_standby), .o_prot_set(o_prot_set), .o_prot_start(o_prot_start),
    .o_prot_count(o_prot_count), .o_he_block(o_he_block), .o_last_cmd(o_last_cmd));
`default_nettype wire
